// ==== design/fss_clkdiv.sv ====
// cascaded prescaler giving serial clock edge ticks
`timescale 1ns/100ps
`include "fss_defs.svh"
module fss_clkdiv #(
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // control
  input wire logic run_in,
  input wire logic [1:0] pri_in,
  input wire logic [2:0] sec_in,
  // one tick per serial clock half period
  output logic tick_out
);
  import fss_pkg::*;

  // ****************************************
  // ratio decoding
  // ****************************************
  // primary field: 64, 16, 4, 1
  function automatic logic [CNT_W-1:0] pri_ratio(input logic [1:0] f);
    logic [9:0] r;
    unique case (f)
      2'b00: r = `FSS_PRI_00;
      2'b01: r = `FSS_PRI_01;
      2'b10: r = `FSS_PRI_10;
      2'b11: r = `FSS_PRI_11;
    endcase
    return CNT_W'(r);
  endfunction

  // secondary field: 8, 6, 4, 2, then 1
  function automatic logic [CNT_W-1:0] sec_ratio(input logic [2:0] f);
    logic [9:0] r;
    unique casez (f)
      3'b000: r = `FSS_SEC_000;
      3'b001: r = `FSS_SEC_001;
      3'b010: r = `FSS_SEC_010;
      3'b011: r = `FSS_SEC_011;
      3'b1??: r = `FSS_SEC_1XX;
    endcase
    return CNT_W'(r);
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } fss_div_t;

  fss_div_t r; // registered state
  fss_div_t next_r; // next state
  logic [2*CNT_W-1:0] prod; // overall divide
  logic [CNT_W-1:0] last; // terminal count

  // divide is the product of both stages
  always_comb begin
    prod = pri_ratio(pri_in) * sec_ratio(sec_in);
    last = prod[CNT_W-1:0] - CNT_W'(1);
    next_r = r;
    next_r.tick = 1'b0;
    if (!run_in) begin
      // held at zero while stopped
      next_r.cnt = '0;
    end else if (r.cnt >= last) begin
      next_r.cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + CNT_W'(1);
    end
  end

  // register the state
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick_out = r.tick;
endmodule

// ==== design/fss_defs.svh ====
// constants of the framed serial sync and clock block
`ifndef FSS_DEFS_SVH
`define FSS_DEFS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FSS_ADDR_W 4
`define FSS_OFS_CTRL 4'h0
`define FSS_OFS_STAT 4'h4
`define FSS_OFS_DATA 4'h8
// ****************************************
// control word bit positions
// ****************************************
`define FSS_B_FRAMED 14
`define FSS_B_FSDIR 13
`define FSS_B_WIDE 10
`define FSS_B_EDGE 8
`define FSS_B_SELEN 7
`define FSS_B_POL 6
`define FSS_B_MASTER 5
`define FSS_F_SEC 4:2
`define FSS_F_PRI 1:0
`define FSS_CTRL_RST 16'h0000
`define FSS_CTRL_MASK 16'h65FF
// ****************************************
// status word bit positions
// ****************************************
`define FSS_B_DONE 7
`define FSS_B_OVF 6
`define FSS_B_TXF 1
`define FSS_B_RXF 0
// ****************************************
// word lengths and divide ratios
// ****************************************
`define FSS_BITS_NARROW 5'h08
`define FSS_BITS_WIDE 5'h10
`define FSS_PRI_00 10'h040
`define FSS_PRI_01 10'h010
`define FSS_PRI_10 10'h004
`define FSS_PRI_11 10'h001
`define FSS_SEC_000 10'h008
`define FSS_SEC_001 10'h006
`define FSS_SEC_010 10'h004
`define FSS_SEC_011 10'h002
`define FSS_SEC_1XX 10'h001
`endif

// ==== design/fss_pkg.sv ====
// types shared by the framed serial sync and clock block
package fss_pkg;
  `include "fss_defs.svh"
  // register port request
  typedef struct packed {
    logic [`FSS_ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } fss_bus_req_t;
  // pins seen from outside
  typedef struct packed {
    logic sck;
    logic fs;
    logic sdi;
  } fss_pin_in_t;
  // pins driven out, enables active low
  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic fs;
    logic fs_oe_n;
    logic sdo;
  } fss_pin_out_t;
  // word engine states
  typedef enum logic [1:0] {
    FSS_IDLE = 2'b00,
    FSS_SYNC = 2'b01,
    FSS_ARM = 2'b10,
    FSS_SHIFT = 2'b11
  } fss_state_t;
endpackage

// ==== design/fss_top.sv ====
// framed serial port: sync pulse, word engine, master clock
//
// Function
// - framed enable uses select pin as sync
// - sync direction bit: clear drives, set receives
// - sync pulse high for one clock
// - framed clock master drives free-running clock
// - polarity bit alone sets edges; edge bit ignored
// - polarity 0: drive on rise, sample fall
// - polarity 1: drive on fall, sample rise
// - frame master: write triggers sync, then load
// - frame slave: sampled sync loads and shifts
// - sync without write resends old holding
// - clock+frame master: sync next edge, data after
// - clock master frame slave: sample sync, transmit
// - clock slave frame master: same as master sync
// - both slave: sample sync, transmit next edge
// - clock from primary then secondary prescaler
// - ratios 1/4/16/64 times 1/2/4/6/8
// - unframed clock runs only per word
// - width bit picks 8 or 16, MSB first
// - word end: store, receive full, done flag
// - unread receive sets overrun, blocks reception
`timescale 1ns/100ps
`include "fss_defs.svh"
module fss_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire fss_pkg::fss_bus_req_t bus_in,
  output logic [15:0] rdata_out,
  // serial pins
  input wire fss_pkg::fss_pin_in_t pins_in,
  output fss_pkg::fss_pin_out_t pins_out
);
  import fss_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] ctrl; // control word
    logic [15:0] txh; // transmit holding
    logic txfull; // holding not yet moved
    logic [15:0] rxh; // receive holding
    logic rxfull; // receive unread
    logic ovf; // sticky overrun
    logic done; // sticky transfer done
    logic [15:0] shf; // word shifter
    logic [4:0] bits; // bits sampled in word
    fss_state_t st; // engine state
    logic sck; // driven clock level
    logic sck_oen; // clock pin enable, low drives
    logic fs; // driven sync level
    logic fs_oen; // sync pin enable, low drives
    logic sdo; // serial data out
    logic [2:0] sck_s; // clock pin synchroniser
    logic [1:0] fs_s; // sync pin synchroniser
    logic [1:0] sdi_s; // data pin synchroniser
    logic [15:0] rdata; // read answer
  } fss_regs_t;

  fss_regs_t r; // registered state
  fss_regs_t next_r; // next state

  // ****************************************
  // helpers
  // ****************************************
  // top bit of the active word
  function automatic logic msb_of(input logic [15:0] v, input logic wide);
    return wide ? v[15] : v[7];
  endfunction

  // bits in one word
  function automatic logic [4:0] word_bits(input logic wide);
    return wide ? `FSS_BITS_WIDE : `FSS_BITS_NARROW;
  endfunction

  // ****************************************
  // decoded control
  // ****************************************
  logic framed; // framed operation
  logic fs_in_mode; // sync received from outside
  logic wide; // sixteen bit words
  logic pol; // idle clock level
  logic master; // clock driven here
  logic run; // master clock running
  logic tick; // master half-period tick
  logic edge_ev; // any clock edge seen
  logic new_lvl; // clock level after the edge
  logic tx_e; // transmit edge
  logic smp_e; // sample edge
  logic [15:0] shifted; // shifter after sampling
  logic last_bit; // this sample ends the word

  assign framed = r.ctrl[`FSS_B_FRAMED];
  assign fs_in_mode = r.ctrl[`FSS_B_FSDIR];
  assign wide = r.ctrl[`FSS_B_WIDE];
  assign pol = r.ctrl[`FSS_B_POL];
  assign master = r.ctrl[`FSS_B_MASTER];
  // free running when framed, else only during a word
  assign run = master && (framed || r.st == FSS_SHIFT);

  // ****************************************
  // prescaler
  // ****************************************
  fss_clkdiv #(
    .CNT_W(10)
  ) u_div (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .run_in(run),
    .pri_in(r.ctrl[`FSS_F_PRI]),
    .sec_in(r.ctrl[`FSS_F_SEC]),
    .tick_out(tick)
  );

  // ****************************************
  // edge classification
  // ****************************************
  // leaving idle level transmits, returning samples
  always_comb begin
    if (master) begin
      edge_ev = tick;
      new_lvl = ~r.sck;
    end else begin
      // external clock, synchronised copies only
      edge_ev = r.sck_s[1] ^ r.sck_s[2];
      new_lvl = r.sck_s[1];
    end
    tx_e = edge_ev && (new_lvl != pol);
    smp_e = edge_ev && (new_lvl == pol);
    shifted = {r.shf[14:0], r.sdi_s[1]};
    last_bit = (r.bits + 5'h01) == word_bits(wide);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r = r;
    // synchronisers: first stage feeds only the second
    next_r.sck_s = {r.sck_s[1:0], pins_in.sck};
    next_r.fs_s = {r.fs_s[0], pins_in.fs};
    next_r.sdi_s = {r.sdi_s[0], pins_in.sdi};
    next_r.rdata = 16'h0000;

    // pin directions
    next_r.sck_oen = ~master;
    next_r.fs_oen = ~(framed && !fs_in_mode);

    // master clock level
    if (!run) begin
      next_r.sck = pol;
    end else if (tick) begin
      next_r.sck = ~r.sck;
    end

    // software clears come first so hardware sets win
    if (bus_in.wr && bus_in.addr == `FSS_OFS_STAT) begin
      // writing zero clears a sticky flag
      if (!bus_in.wdata[`FSS_B_OVF]) begin
        next_r.ovf = 1'b0;
      end
      if (!bus_in.wdata[`FSS_B_DONE]) begin
        next_r.done = 1'b0;
      end
    end
    if (bus_in.rd && bus_in.addr == `FSS_OFS_DATA) begin
      next_r.rxfull = 1'b0;
    end

    // word engine
    unique case (r.st)
      FSS_IDLE: begin
        if (!framed) begin
          // plain mode: a pending word starts at once
          if (r.txfull) begin
            next_r.shf = r.txh;
            next_r.sdo = msb_of(r.txh, wide);
            next_r.bits = 5'h00;
            next_r.txfull = 1'b0;
            next_r.st = FSS_SHIFT;
          end
        end else if (!fs_in_mode) begin
          // frame master: a pending write raises sync
          if (tx_e && r.txfull) begin
            next_r.fs = 1'b1;
            next_r.st = FSS_SYNC;
          end
        end else if (smp_e && r.fs_s[1]) begin
          // frame slave: sync seen on a sample edge
          next_r.st = FSS_ARM;
        end
      end
      FSS_SYNC: begin
        // pulse ends one clock later, word loads
        if (tx_e) begin
          next_r.fs = 1'b0;
          next_r.shf = r.txh;
          next_r.sdo = msb_of(r.txh, wide);
          next_r.bits = 5'h00;
          next_r.txfull = 1'b0;
          next_r.st = FSS_SHIFT;
        end
      end
      FSS_ARM: begin
        // load old or new holding, written or not
        if (tx_e) begin
          next_r.shf = r.txh;
          next_r.sdo = msb_of(r.txh, wide);
          next_r.bits = 5'h00;
          next_r.txfull = 1'b0;
          next_r.st = FSS_SHIFT;
        end
      end
      FSS_SHIFT: begin
        if (smp_e) begin
          // sample into bit zero
          next_r.shf = shifted;
          next_r.bits = r.bits + 5'h01;
          if (last_bit) begin
            // word done; idle again allows next sync
            next_r.st = FSS_IDLE;
            next_r.done = 1'b1;
            if (r.ovf) begin
              // reception blocked until overrun cleared
              next_r.rxh = r.rxh;
            end else if (r.rxfull) begin
              next_r.ovf = 1'b1;
            end else begin
              next_r.rxh = wide ? shifted : {8'h00, shifted[7:0]};
              next_r.rxfull = 1'b1;
            end
          end
        end else if (tx_e && r.bits != 5'h00) begin
          // next bit out, top first
          next_r.sdo = msb_of(r.shf, wide);
        end
      end
    endcase

    // software writes last so a new word stays pending
    if (bus_in.wr && bus_in.addr == `FSS_OFS_CTRL) begin
      next_r.ctrl = bus_in.wdata & `FSS_CTRL_MASK;
    end
    if (bus_in.wr && bus_in.addr == `FSS_OFS_DATA) begin
      next_r.txh = bus_in.wdata;
      next_r.txfull = 1'b1;
    end

    // read answer, zero for unmapped addresses
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `FSS_OFS_CTRL: next_r.rdata = r.ctrl;
        `FSS_OFS_STAT: begin
          next_r.rdata[`FSS_B_DONE] = r.done;
          next_r.rdata[`FSS_B_OVF] = r.ovf;
          next_r.rdata[`FSS_B_TXF] = r.txfull;
          next_r.rdata[`FSS_B_RXF] = r.rxfull;
        end
        `FSS_OFS_DATA: next_r.rdata = r.rxh;
        default: next_r.rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // asynchronous reset to constants only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
      r.ctrl <= `FSS_CTRL_RST;
      r.st <= FSS_IDLE;
      r.sck_oen <= 1'b1;
      r.fs_oen <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  assign rdata_out = r.rdata;
  assign pins_out.sck = r.sck;
  assign pins_out.sck_oe_n = r.sck_oen;
  assign pins_out.fs = r.fs;
  assign pins_out.fs_oe_n = r.fs_oen;
  assign pins_out.sdo = r.sdo;
endmodule

// ==== tb/fss_far_end.sv ====
// far-end peripheral: external clock, sync source, data loopback
`timescale 1ns/100ps
module fss_far_end (
  // clock
  input wire logic clk_in,
  // bench controls
  input wire logic run_in,
  input wire logic pol_in,
  input wire logic sync_req_in,
  // device pins
  input wire fss_pkg::fss_pin_out_t dev_in,
  output fss_pkg::fss_pin_in_t line_out
);
  import fss_pkg::*;
  logic ck = 1'b0; // own serial clock
  logic fs = 1'b0; // own sync pulse
  logic req = 1'b0; // sync pending
  logic last = 1'b0; // previous wire clock
  logic [3:0] cnt = 4'h0; // half period count
  logic line_ck; // clock on the wire
  // wire clock from whoever drives the pin
  assign line_ck = dev_in.sck_oe_n ? ck : dev_in.sck;
  assign line_out.sck = line_ck;
  assign line_out.fs = dev_in.fs_oe_n ? fs : dev_in.fs;
  assign line_out.sdi = dev_in.sdo;
  // continuous clock while asked, idle at polarity level
  always @(posedge clk_in) begin
    last <= line_ck;
    if (!run_in) begin
      cnt <= 4'h0;
      ck <= pol_in;
    end else if (cnt == 4'h5) begin
      cnt <= 4'h0;
      ck <= ~ck;
    end else begin
      cnt <= cnt + 4'h1;
    end
    // sync set on a transmit edge, cleared on the next one
    if (line_ck != last && line_ck != pol_in) begin
      fs <= req;
      req <= sync_req_in;
    end else if (sync_req_in) begin
      req <= 1'b1;
    end
  end
endmodule

// ==== tb/fss_top_monitor.sv ====
// port checker for the framed serial block
`timescale 1ns/100ps
`include "fss_defs.svh"
module fss_top_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire fss_pkg::fss_bus_req_t bus_in,
  input wire logic [15:0] rdata_out,
  // serial pins
  input wire fss_pkg::fss_pin_in_t pins_in,
  input wire fss_pkg::fss_pin_out_t pins_out
);
  import fss_pkg::*;
  // ****************************************
  // control shadow and sync counters
  // ****************************************
  logic [15:0] ctl; // control word as written
  logic [15:0] hi_n; // cycles sync stood high
  logic [15:0] lo_n; // cycles since sync fell
  logic [15:0] pri; // primary ratio
  logic [15:0] div; // clk cycles per serial half period
  // divide from the two prescaler fields
  always_comb begin
    case (ctl[1:0])
      2'h0: pri = 16'h0040;
      2'h1: pri = 16'h0010;
      2'h2: pri = 16'h0004;
      default: pri = 16'h0001;
    endcase
    case (ctl[4:2])
      3'h0: div = pri * 16'h0008;
      3'h1: div = pri * 16'h0006;
      3'h2: div = pri * 16'h0004;
      3'h3: div = pri * 16'h0002;
      default: div = pri;
    endcase
  end
  // follow control writes and sync pulse lengths
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl <= 16'h0000;
      hi_n <= 16'h0000;
      lo_n <= 16'hFFFF;
    end else begin
      if (bus_in.wr && bus_in.addr == `FSS_OFS_CTRL) begin
        ctl <= bus_in.wdata & `FSS_CTRL_MASK;
      end
      hi_n <= pins_out.fs ? hi_n + 16'h0001 : 16'h0000;
      lo_n <= pins_out.fs ? 16'h0000 : lo_n + {15'h0000, lo_n != 16'hFFFF};
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // ****************************************
  // assertions
  // ****************************************
  a_ctrl_read_back: assert property (
    $past(bus_in.rd) && $past(bus_in.addr) == `FSS_OFS_CTRL |-> rdata_out == $past(ctl))
    else $error("control word read back differs");
  a_sync_pin_dir: assert property (
    pins_out.fs_oe_n == !($past(ctl[14]) && !$past(ctl[13])))
    else $error("sync pin direction wrong");
  a_clock_pin_dir: assert property (
    pins_out.sck_oe_n == !$past(ctl[5]))
    else $error("clock pin direction wrong");
  a_sync_one_period: assert property (
    $fell(pins_out.fs) && !pins_out.sck_oe_n && !pins_out.fs_oe_n |-> hi_n == 2 * div)
    else $error("sync pulse length wrong");
  a_sync_word_gap: assert property (
    $rose(pins_out.fs) && !pins_out.sck_oe_n |-> lo_n >= (ctl[10] ? 32 : 16) * div)
    else $error("sync pulse inside a word");
  a_sync_tx_edge: assert property (
    $changed(pins_out.fs) && !pins_out.fs_oe_n && !pins_out.sck_oe_n
    |-> $changed(pins_out.sck) && pins_out.sck != ctl[6])
    else $error("sync moved off the transmit edge");
  a_data_tx_edge: assert property (
    $changed(pins_out.sdo) && ctl[14] && !pins_out.sck_oe_n
    |-> $changed(pins_out.sck) && pins_out.sck != ctl[6])
    else $error("data moved off the transmit edge");
  a_clock_free_run: assert property (
    ctl[14] && ctl[5] |-> ##[1:600] $changed(pins_out.sck))
    else $error("framed master clock stopped");
endmodule

// ==== tb/test_fss_top.sv ====
// self-checking bench for the framed serial block
`timescale 1ns/100ps
`include "fss_defs.svh"
module test_fss_top;
  import fss_pkg::*;
  logic clk_in = 1'b0; // 25 MHz clock
  logic arst_n_in = 1'b0; // reset, active low
  fss_bus_req_t bus_in = '0; // register requests
  logic [15:0] rdata_out; // read data
  fss_pin_in_t pins_in; // pins seen by the device
  fss_pin_out_t pins_out; // device pin drive
  logic far_run = 1'b0; // external clock runs
  logic far_pol = 1'b0; // far end polarity
  logic far_sync = 1'b0; // ask far end for a sync
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] modes [6] = '{16'h4430, 16'h4431, 16'h442E, 16'h4423, 16'h4427, 16'h446B};
  always #20 clk_in = ~clk_in;
  fss_top i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .pins_in(pins_in), .pins_out(pins_out));
  fss_far_end i_far (.clk_in(clk_in), .run_in(far_run), .pol_in(far_pol),
    .sync_req_in(far_sync), .dev_in(pins_out), .line_out(pins_in));
  // verdict and end of run
  task automatic close_out;
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      close_out();
    end
  end
  // one-cycle write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus_in <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask
  // one-cycle read, data taken the cycle after
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    bus_in <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1 d = rdata_out;
  endtask
  // read and compare
  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    rd(a, d);
    comparisons++;
    if (d !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, d);
    end
  endtask
  // poll status until the word is done
  task automatic wait_done;
    logic [15:0] s;
    s = 16'h0000;
    while (s[`FSS_B_DONE] !== 1'b1) begin
      rd(`FSS_OFS_STAT, s);
    end
  endtask
  // one word: load, optional far sync, check and clear
  task automatic xfer(input logic ld, input logic sy, input logic [15:0] d,
                      input logic [15:0] exp);
    if (ld) begin
      wr(`FSS_OFS_DATA, d);
    end
    if (sy) begin
      @(posedge clk_in);
      far_sync <= 1'b1;
      @(posedge clk_in);
      far_sync <= 1'b0;
    end
    wait_done();
    rc(`FSS_OFS_STAT, 16'h0081, "status");
    rc(`FSS_OFS_DATA, exp, "rx word");
    wr(`FSS_OFS_STAT, 16'h0000);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rc(`FSS_OFS_CTRL, 16'h0000, "ctrl reset");
    rc(`FSS_OFS_STAT, 16'h0000, "stat reset");
    rc(4'hC, 16'h0000, "unmapped");
    wr(`FSS_OFS_CTRL, 16'hFFFF);
    rc(`FSS_OFS_CTRL, `FSS_CTRL_MASK, "ctrl mask");
    // clock and frame master over each primary and each secondary divider code
    for (int i = 0; i < 6; i++) begin
      far_pol <= modes[i][6];
      wr(`FSS_OFS_CTRL, modes[i]);
      xfer(1'b1, 1'b0, ~modes[i], ~modes[i]);
    end
    far_pol <= 1'b0;
    wr(`FSS_OFS_CTRL, 16'h4023);
    xfer(1'b1, 1'b0, 16'hA5C3, 16'h00C3);
    // second word while the first is unread
    wr(`FSS_OFS_DATA, 16'h1234);
    wait_done();
    wr(`FSS_OFS_STAT, 16'h0000);
    wr(`FSS_OFS_DATA, 16'h5678);
    wait_done();
    rc(`FSS_OFS_STAT, 16'h00C1, "overrun");
    rc(`FSS_OFS_DATA, 16'h0034, "kept word");
    wr(`FSS_OFS_STAT, 16'h0000);
    rc(`FSS_OFS_STAT, 16'h0000, "ovf clear");
    // unframed master: clock runs only for the word
    wr(`FSS_OFS_CTRL, 16'h0423);
    xfer(1'b1, 1'b0, 16'h9A6B, 16'h9A6B);
    // frame slave, then a sync with no new load
    wr(`FSS_OFS_CTRL, 16'h6423);
    xfer(1'b1, 1'b1, 16'h3C96, 16'h3C96);
    xfer(1'b0, 1'b1, 16'h0000, 16'h3C96);
    // external clock for both sync directions
    far_run <= 1'b1;
    wr(`FSS_OFS_CTRL, 16'h4400);
    xfer(1'b1, 1'b0, 16'hB1E4, 16'hB1E4);
    wr(`FSS_OFS_CTRL, 16'h6400);
    xfer(1'b1, 1'b1, 16'h6D2B, 16'h6D2B);
    close_out();
  end
endmodule
bind fss_top fss_top_monitor i_mon (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus_in),
  .rdata_out(rdata_out), .pins_in(pins_in), .pins_out(pins_out));
